// ===== hdl/sdram_mode_burst_timing.sv
/*
 * Synchronous DRAM device core: command decode, clock gate, bank/row state,
 * mode word, burst column sequencing, write masking and the read latency
 * pipeline with its output enables.
 * Assumes all pins synchronous to clk and a controller that keeps its own
 * spacing; dq is split into dq_in, dq_out and per-lane active-low enables.
 */
`timescale 1ns/100ps
`include "sdram_defines.svh"

module sdram_mode_burst_timing
	import sdram_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  cke,
	input  wire logic                  cs_n,
	input  wire logic                  ras_n,
	input  wire logic                  cas_n,
	input  wire logic                  we_n,
	input  wire logic                  bank_select_bit0,
	input  wire logic                  bank_select_bit1,
	input  wire logic [`ROW_BITS-1:0]  addr,
	input  wire logic [`LANES-1:0]     dqm,
	input  wire logic [`WORD_BITS-1:0] dq_in,
	output logic      [`WORD_BITS-1:0] dq_out,
	output logic      [`LANES-1:0]     dq_oe_n
);

	state_s                    s_r;
	state_s                    s_nxt;
	cmd_e                      cmd;
	logic [`BANK_BITS-1:0]     cmd_bank;
	logic [`BANK_BITS-1:0]     iss_bank;
	logic [`COL_BITS-1:0]      iss_start;
	logic [`COL_BITS-1:0]      iss_beat;
	logic [`COL_BITS-1:0]      iss_len_m1;
	logic                      iss_inter;
	logic [`COL_BITS-1:0]      iss_col;
	logic                      iss_rd;
	logic                      iss_wr;
	logic [`COL_BITS-1:0]      mode_len_m1;
	logic                      mode_full;
	logic                      mode_cl3;
	logic                      mode_normal;
	logic [`WORD_BITS-1:0]     rd_word;
	logic [21:0]               mem_idx;

	// length field to block mask; reserved codes behave as a single beat
	always_comb
	begin
		mode_full = 1'b0;
		case (s_r.mode[`BL_MSB:`BL_LSB])
			`BL_2:    mode_len_m1 = 8'h01;
			`BL_4:    mode_len_m1 = 8'h03;
			`BL_8:    mode_len_m1 = 8'h07;
			`BL_PAGE:
			begin
				mode_len_m1 = 8'hff;
				mode_full   = 1'b1;
			end
			default:  mode_len_m1 = 8'h00;
		endcase
		// only the two-clock code selects two; reserved codes fall to three
		mode_cl3    = (s_r.mode[`CL_MSB:`CL_LSB] != `CL_TWO);
		mode_normal = (s_r.mode[`OPM_MSB:`OPM_LSB] == 2'b00);
	end

	// pin decode; a low clock gate sampled last edge masks this edge
	always_comb
	begin
		cmd_bank = {bank_select_bit1, bank_select_bit0};
		if (!s_r.cke_q || cs_n)
			cmd = CMD_NOP;
		else
		begin
			case ({ras_n, cas_n, we_n})
				`PIN_ACT:   cmd = CMD_ACT;
				`PIN_READ:  cmd = CMD_READ;
				`PIN_WRITE: cmd = CMD_WRITE;
				`PIN_PRE:   cmd = CMD_PRE;
				`PIN_REF:   cmd = CMD_REF;
				`PIN_MRS:   cmd = CMD_MRS;
				`PIN_STOP:  cmd = CMD_STOP;
				default:    cmd = CMD_NOP;
			endcase
		end
	end

	// beat issued this edge: a fresh column command wins over a running burst
	always_comb
	begin
		iss_rd     = 1'b0;
		iss_wr     = 1'b0;
		iss_bank   = s_r.bbank;
		iss_start  = s_r.bstart;
		iss_beat   = s_r.beat;
		iss_len_m1 = s_r.blen_m1;
		iss_inter  = s_r.mode[`BT_BIT] && !s_r.bfull;
		if ((cmd == CMD_READ || cmd == CMD_WRITE) && s_r.open_bank[cmd_bank] && mode_normal)
		begin
			iss_bank   = cmd_bank;
			iss_start  = addr[`COL_BITS-1:0];
			iss_beat   = 8'h00;
			iss_rd     = (cmd == CMD_READ);
			iss_wr     = (cmd == CMD_WRITE);
			iss_len_m1 = (iss_wr && s_r.mode[`WBM_BIT]) ? 8'h00 : mode_len_m1;
			iss_inter  = s_r.mode[`BT_BIT] && !mode_full;
		end
		else if (cmd != CMD_READ && cmd != CMD_WRITE && cmd != CMD_STOP && s_r.cke_q)
		begin
			// a precharge to the burst's bank ends it at this very edge
			if (!(cmd == CMD_PRE && (addr[`AP_BIT] || cmd_bank == s_r.bbank)))
			begin
				iss_rd = (s_r.bst == BST_READ);
				iss_wr = (s_r.bst == BST_WRITE);
			end
		end
	end

	burst_col_order u_order
	(
		.start_col  (iss_start),
		.beat       (iss_beat),
		.len_m1     (iss_len_m1),
		.interleave (iss_inter),
		.col        (iss_col)
	);

	assign mem_idx = {iss_bank, s_r.open_row[iss_bank], iss_col};

	// byte lanes of storage; the write mask gates the word of the same edge
	genvar g;
	generate
		for (g = 0; g < `LANES; g++)
		begin : g_lane
			logic [7:0] lane_mem [`MEM_WORDS];
			always_ff @(posedge clk)
			begin
				if (!srst && iss_wr && !dqm[g])
					lane_mem[mem_idx] <= dq_in[g*8 +: 8];
			end
			assign rd_word[g*8 +: 8] = lane_mem[mem_idx];
		end
	endgenerate

	// next state: command effects, burst advance and the read pipeline
	always_comb
	begin
		s_nxt       = s_r;
		s_nxt.cke_q = cke;
		if (s_r.cke_q)
		begin
			// two stage pipe: stage 0 loads at edge n, dq at n+1 or n+2
			s_nxt.p0v   = iss_rd;
			s_nxt.p0d   = rd_word;
			s_nxt.p1v   = s_r.p0v;
			s_nxt.p1d   = s_r.p0d;
			s_nxt.dqm_q = dqm;
			s_nxt.dq_out = mode_cl3 ? s_r.p1d : s_r.p0d;
			for (int i = 0; i < `LANES; i++)
				s_nxt.dq_oe_n[i] = !((mode_cl3 ? s_r.p1v : s_r.p0v) && !s_r.dqm_q[i]);

			// running burst walks on or ends at its last beat
			if (s_r.bst != BST_IDLE && (iss_rd || iss_wr) && iss_beat == s_r.beat && iss_start == s_r.bstart)
			begin
				s_nxt.beat = s_r.beat + 8'h01;
				if (s_r.beat == s_r.blen_m1 && !s_r.bfull)
				begin
					s_nxt.bst = BST_IDLE;
					if (s_r.bap)
						s_nxt.open_bank[s_r.bbank] = 1'b0;
				end
			end

			case (cmd)
				CMD_ACT:
					if (!s_r.open_bank[cmd_bank])
					begin
						s_nxt.open_bank[cmd_bank] = 1'b1;
						s_nxt.open_row[cmd_bank]  = addr;
					end
				CMD_PRE:
				begin
					if (addr[`AP_BIT])
						s_nxt.open_bank = 4'h0;
					else
						s_nxt.open_bank[cmd_bank] = 1'b0;
					if (addr[`AP_BIT] || cmd_bank == s_r.bbank)
						s_nxt.bst = BST_IDLE;
				end
				CMD_READ, CMD_WRITE:
					if (iss_rd || iss_wr)
					begin
						s_nxt.bbank   = cmd_bank;
						s_nxt.bstart  = iss_start;
						s_nxt.blen_m1 = iss_len_m1;
						s_nxt.bfull   = mode_full && iss_len_m1 != 8'h00;
						s_nxt.bap     = addr[`AP_BIT];
						s_nxt.beat    = 8'h01;
						s_nxt.bst     = iss_rd ? BST_READ : BST_WRITE;
						if (iss_len_m1 == 8'h00)
						begin
							s_nxt.bst = BST_IDLE;
							if (addr[`AP_BIT])
								s_nxt.open_bank[cmd_bank] = 1'b0;
						end
						// a write takes the bus: pending read data is dropped
						if (iss_wr)
						begin
							s_nxt.p0v     = 1'b0;
							s_nxt.p1v     = 1'b0;
							s_nxt.dq_oe_n = '1;
						end
					end
				CMD_STOP:
					s_nxt.bst = BST_IDLE;
				CMD_MRS:
					// loads while banks are busy would corrupt timing, so they are dropped
					if (s_r.open_bank == 4'h0 && s_r.bst == BST_IDLE)
						s_nxt.mode = addr;
				default:
					s_nxt.bst = s_nxt.bst;
			endcase
		end
		// synchronous reset; real parts have none, so the mode word gets a fixed value
		if (srst)
		begin
			s_nxt         = '0;
			s_nxt.mode    = `MODE_RST;
			s_nxt.bst     = BST_IDLE;
			s_nxt.dq_oe_n = '1;
		end
	end

	// single state register
	always_ff @(posedge clk)
	begin
		s_r <= s_nxt;
	end

	assign dq_out  = s_r.dq_out;
	assign dq_oe_n = s_r.dq_oe_n;

endmodule

// ===== hdl/sdram_defines.svh
/*
 * Constants for the synchronous DRAM device model: array geometry, mode word
 * field positions, command pin encodings and cycle counts.
 * Assumes nothing; included by the package and the design modules.
 */
`ifndef SDRAM_DEFINES_SVH
`define SDRAM_DEFINES_SVH

// array geometry
`define BANK_BITS       2
`define ROW_BITS        12
`define COL_BITS        8
`define WORD_BITS       16
`define LANES           2
`define MEM_WORDS       (1 << (`BANK_BITS + `ROW_BITS + `COL_BITS))

// operating_mode_word fields
`define MODE_BITS       12
`define BL_LSB          0
`define BL_MSB          2
`define BT_BIT          3
`define CL_LSB          4
`define CL_MSB          6
`define OPM_LSB         7
`define OPM_MSB         8
`define WBM_BIT         9
`define MODE_RST        12'h000

// burst length field codes
`define BL_1            3'h1 - 3'h1
`define BL_2            3'h1
`define BL_4            3'h2
`define BL_8            3'h3
`define BL_PAGE         3'h7

// read_latency_setting code for two clocks; other legal code is three
`define CL_TWO          3'h2

// auto precharge / all-bank address bit
`define AP_BIT          10

// command pin code {ras_n, cas_n, we_n}
`define PIN_ACT         3'h3
`define PIN_READ        3'h5
`define PIN_WRITE       3'h4
`define PIN_PRE         3'h2
`define PIN_REF         3'h1
`define PIN_MRS         3'h0
`define PIN_STOP        3'h6

// cycle figures
`define CCD_CYC         1
`define CKE_DELAY_CYC   1
`define WRITE_MASK_LAT  0
`define READ_MASK_LAT   2
`define MRD_CYC         2

`endif

// ===== hdl/sdram_pkg.sv
/*
 * Types for the synchronous DRAM device model: command and burst enums and
 * the packed state record of the main module.
 * Assumes sdram_defines.svh is on the include path.
 */
`include "sdram_defines.svh"

package sdram_pkg;

	typedef enum logic [3:0]
	{
		CMD_NOP,
		CMD_ACT,
		CMD_READ,
		CMD_WRITE,
		CMD_PRE,
		CMD_REF,
		CMD_MRS,
		CMD_STOP
	} cmd_e;

	typedef enum logic [2:0]
	{
		BST_IDLE  = 3'b001,
		BST_READ  = 3'b010,
		BST_WRITE = 3'b100
	} burst_state_e;

	typedef struct packed
	{
		logic                                     cke_q;
		logic [`MODE_BITS-1:0]                    mode;
		logic [3:0]                               open_bank;
		logic [3:0][`ROW_BITS-1:0]                open_row;
		burst_state_e                             bst;
		logic [`BANK_BITS-1:0]                    bbank;
		logic [`COL_BITS-1:0]                     bstart;
		logic [`COL_BITS-1:0]                     beat;
		logic [`COL_BITS-1:0]                     blen_m1;
		logic                                     bfull;
		logic                                     bap;
		logic                                     p0v;
		logic [`WORD_BITS-1:0]                    p0d;
		logic                                     p1v;
		logic [`WORD_BITS-1:0]                    p1d;
		logic [`LANES-1:0]                        dqm_q;
		logic [`WORD_BITS-1:0]                    dq_out;
		logic [`LANES-1:0]                        dq_oe_n;
	} state_s;

endpackage

// ===== hdl/burst_col_order.sv
/*
 * Column order within a burst: the column for a given beat from the start
 * column, the block mask (burst length minus one) and the burst type.
 * Assumes the caller forces sequential order for full-page bursts.
 */
`timescale 1ns/100ps
`include "sdram_defines.svh"

module burst_col_order
	import sdram_pkg::*;
(
	input  wire logic [`COL_BITS-1:0] start_col,
	input  wire logic [`COL_BITS-1:0] beat,
	input  wire logic [`COL_BITS-1:0] len_m1,
	input  wire logic                 interleave,
	output logic      [`COL_BITS-1:0] col
);

	logic [`COL_BITS-1:0] low_part;

	// high bits pick the aligned block, low bits walk inside it and wrap
	always_comb
	begin
		if (interleave)
			low_part = start_col ^ beat;
		else
			low_part = start_col + beat;
		col = (start_col & ~len_m1) | (low_part & len_m1);
	end

endmodule

// ===== test/sdram_checker.sv
/* pin-level timing checks for the dram device core.
   assumes reads target open banks and mode loads happen with banks idle */
`timescale 1ns/100ps
`include "sdram_defines.svh"
module sdram_checker
	import sdram_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [11:0] addr,
	input wire logic [1:0]  dqm,
	input wire logic [15:0] dq_out,
	input wire logic [1:0]  dq_oe_n
);
	logic        cke_p_r;
	logic [11:0] mode_r;
	logic        take;
	logic        rd;
	logic        wr;
	logic        pre_all;
	logic        cl2;
	logic        bl4;

	// decode; the clock gate acts one edge late
	assign take = !cs_n && cke_p_r;
	assign rd = take && {ras_n, cas_n, we_n} == `PIN_READ;
	assign wr = take && {ras_n, cas_n, we_n} == `PIN_WRITE;
	assign pre_all = take && {ras_n, cas_n, we_n} == `PIN_PRE && addr[`AP_BIT];
	assign cl2 = mode_r[`CL_MSB:`CL_LSB] == `CL_TWO;
	assign bl4 = mode_r[`BL_MSB:`BL_LSB] == `BL_4;

	// shadow mode word, needed to know the latency of each read
	always_ff @(posedge clk)
	begin
		cke_p_r <= srst ? 1'b0 : cke;
		mode_r <= srst ? `MODE_RST : ((take && {ras_n, cas_n, we_n} == `PIN_MRS) ? addr : mode_r);
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence quiet_s;
		cke && cs_n && dqm == 2'h0;
	endsequence

	rd_lat_two_a: assert property (rd && cl2 |-> ##2 dq_oe_n == $past(dqm, 2))
		else $error("first read word not driven at latency two");
	rd_lat_three_a: assert property (rd && !cl2 |-> ##3 dq_oe_n == $past(dqm, 2))
		else $error("first read word not driven at latency three");
	mask_float_a: assert property (|dqm |-> ##2 (dq_oe_n & $past(dqm, 2)) == $past(dqm, 2))
		else $error("masked lane driven two cycles after mask");
	suspend_hold_a: assert property (!cke |=> ##1 $stable(dq_oe_n) && $stable(dq_out))
		else $error("outputs moved while clock gated");
	burst_len_a: assert property (rd && cl2 && bl4 && dqm == 2'h0 ##1 quiet_s [*5]
		|-> dq_oe_n == 2'h0 ##1 dq_oe_n == 2'h3)
		else $error("length four burst wrong span");
	pre_float_two_a: assert property (pre_all && cl2 |-> ##2 dq_oe_n == 2'h3)
		else $error("lanes not floated after precharge at latency two");
	pre_float_three_a: assert property (pre_all && !cl2 |-> ##3 dq_oe_n == 2'h3)
		else $error("lanes not floated after precharge at latency three");
	wr_float_a: assert property (wr |=> dq_oe_n == 2'h3)
		else $error("lanes driven during write");

	cover property (rd && cl2);
	cover property (rd && !cl2);
	cover property (wr && |dqm);
	cover property (pre_all && cl2);
	cover property (cke ##1 !cke ##1 cke);
endmodule

bind sdram_mode_burst_timing sdram_checker i_chk (.clk(clk), .srst(srst), .cke(cke), .cs_n(cs_n),
	.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .dqm(dqm), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

// ===== test/ctl_model.sv
/* memory controller model: drives command, address, mask and write data.
   assumes its tasks are called right after a rising clock edge */
`timescale 1ns/100ps
`include "sdram_defines.svh"
module ctl_model
#(
	parameter int POWERUP_CYC = 10000
)
(
	input  wire logic   clk,
	output logic        cke,
	output logic        cs_n,
	output logic [2:0]  cmd,
	output logic [1:0]  bank,
	output logic [11:0] addr,
	output logic [1:0]  dqm,
	output logic [15:0] dq_in
);
	// gate low and mask high until power-up
	initial
	begin
		cke = 1'b0;
		cs_n = 1'b1;
		cmd = 3'h7;
		bank = 2'h0;
		addr = 12'h000;
		dqm = 2'h3;
		dq_in = 16'h0000;
	end

	// one command per cycle; a released data line toggles so no stale word looks valid
	task automatic drv(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [1:0] m, input logic [15:0] d);
		cke <= 1'b1;
		cs_n <= (c == 3'h7);
		cmd <= c;
		bank <= b;
		addr <= a;
		dqm <= m;
		dq_in <= (c == `PIN_WRITE) ? d : ~dq_in;
		@(posedge clk);
	endtask

	// clock gate low with the chip deselected, one cycle per count
	task automatic gate(input int n);
		repeat (n)
		begin
			cke <= 1'b0;
			cs_n <= 1'b1;
			@(posedge clk);
		end
	endtask

	task automatic nop(input int n);
		repeat (n) drv(3'h7, 2'h0, 12'h000, 2'h0, 16'h0000);
	endtask

	// power-up wait, precharge all, two refreshes
	task automatic init();
		@(posedge clk);
		repeat (POWERUP_CYC) drv(3'h7, 2'h0, 12'h000, 2'h3, 16'h0000);
		drv(`PIN_PRE, 2'h0, 12'h400, 2'h0, 16'h0000);
		nop(1);
		drv(`PIN_REF, 2'h0, 12'h000, 2'h0, 16'h0000);
		nop(1);
		drv(`PIN_REF, 2'h0, 12'h000, 2'h0, 16'h0000);
	endtask

	// idle banks, load the mode word, open one row
	task automatic setup(input logic [11:0] m, input logic [1:0] b, input logic [11:0] r);
		nop(2);
		drv(`PIN_PRE, 2'h0, 12'h400, 2'h0, 16'h0000);
		nop(1);
		drv(`PIN_MRS, 2'h0, m, 2'h0, 16'h0000);
		nop(1);
		drv(`PIN_ACT, b, r, 2'h0, 16'h0000);
	endtask
endmodule

// ===== test/sdram_mode_burst_timing_tb.sv
/* bench: fills one column block with masked writes, then reads it back
   under every length, order and latency; assumes ctl_model and the checker */
`timescale 1ns/100ps
`include "sdram_defines.svh"
module sdram_mode_burst_timing_tb;
	logic        clk;
	logic        srst;
	logic        cke;
	logic        cs_n;
	logic [2:0]  cmd;
	logic [1:0]  bank;
	logic [1:0]  dqm;
	logic [1:0]  dq_oe_n;
	logic [11:0] addr;
	logic [15:0] dq_in;
	logic [15:0] dq_out;
	logic [15:0] mem_exp [8];
	int          fail_count;
	int          checks_done;
	int          cycles;
	logic [1:0]  bk;
	logic [11:0] row;

	sdram_mode_burst_timing i_dut (.clk(clk), .srst(srst), .cke(cke), .cs_n(cs_n), .ras_n(cmd[2]),
		.cas_n(cmd[1]), .we_n(cmd[0]), .bank_select_bit0(bank[0]), .bank_select_bit1(bank[1]),
		.addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
	ctl_model i_ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd(cmd), .bank(bank), .addr(addr),
		.dqm(dqm), .dq_in(dq_in));

	function automatic logic [7:0] col_at(input logic [7:0] s, input logic [7:0] b,
		input logic [7:0] m, input logic il);
		col_at = (s & ~m) | ((il ? s ^ b : s + b) & m);
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one read burst from column st under the loaded mode; each beat compared while it stands
	task automatic rd_chk(input logic [2:0] st, input int len, input int lat, input logic il,
		input logic [1:0] m);
		logic [1:0]  oe;
		logic [15:0] lm;
		i_ctl.drv(`PIN_READ, bk, {9'h000, st}, m, 16'h0000);
		for (int b = 0; b < len; b++)
		begin
			i_ctl.nop(b == 0 ? lat - 1 : 1);
			#1;
			oe = (b == 0 && lat == 2) ? m : 2'h0;
			lm = {{8{~oe[1]}}, {8{~oe[0]}}};
			check("lane enables", 16'(oe), 16'(dq_oe_n));
			check("read word", mem_exp[col_at(8'(st), 8'(b), 8'(len - 1), il)] & lm, dq_out & lm);
		end
		i_ctl.nop(1);
		#1;
		check("float after burst", 16'h0003, 16'(dq_oe_n));
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// a hang ends the run as a mismatch
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end

	initial
	begin
		logic [2:0]  st;
		logic [15:0] d;
		logic [15:0] lm;
		logic [1:0]  m;
		int          len;
		int          lat;
		int          b_exp;
		srst = 1'b1;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		void'($urandom(98501));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		bk = 2'($urandom);
		row = 12'($urandom);
		i_ctl.init();
		i_ctl.setup(12'h030, bk, row);
		// plain pass then masked pass, one write per cycle
		for (int i = 0; i < 16; i++)
		begin
			d = 16'($urandom);
			m = (i < 8) ? 2'h0 : 2'($urandom);
			lm = {{8{m[1]}}, {8{m[0]}}};
			mem_exp[i % 8] = (d & ~lm) | (mem_exp[i % 8] & lm);
			i_ctl.drv(`PIN_WRITE, bk, 12'(i % 8), m, d);
		end
		$display("test write fill done");
		for (int i = 0; i < 16; i++)
		begin
			len = 1 << i[1:0];
			lat = i[3] ? 2 : 3;
			st = 3'($urandom);
			m = {i[2], i[0]};
			i_ctl.setup({5'h00, 3'(lat), i[2], 1'b0, i[1:0]}, bk, row);
			rd_chk(st, len, lat, i[2], m);
			$display("test read config %0d done", i);
		end
		// full page with the order bit set still runs upward; a precharge cuts it after four beats
		for (int lt = 2; lt < 4; lt++)
		begin
			st = 3'($urandom % 5);
			i_ctl.setup({5'h00, 3'(lt), 1'b1, 3'h7}, bk, row);
			i_ctl.drv(`PIN_READ, bk, {9'h000, st}, 2'h0, 16'h0000);
			for (int k = 1; k <= lt + 3; k++)
			begin
				if (k == 4)
					i_ctl.drv(`PIN_PRE, bk, (lt == 2) ? 12'h400 : 12'h000, 2'h0, 16'h0000);
				else
					i_ctl.nop(1);
				#1;
				if (k == lt + 3)
					check("float after precharge", 16'h0003, 16'(dq_oe_n));
				else if (k >= lt - 1)
				begin
					check("page enables", 16'h0000, 16'(dq_oe_n));
					check("page word", mem_exp[st + 3'(k - lt + 1)], dq_out);
				end
			end
			$display("test page cut latency %0d done", lt);
		end
		// clock gate low for one edge inside a burst: the beat stretches and the write is ignored
		i_ctl.setup(12'h022, bk, row);
		i_ctl.drv(`PIN_READ, bk, 12'h000, 2'h0, 16'h0000);
		for (int k = 1; k <= 6; k++)
		begin
			if (k == 2)
				i_ctl.gate(1);
			else if (k == 3)
				i_ctl.drv(`PIN_WRITE, bk, 12'h000, 2'h0, ~mem_exp[0]);
			else
				i_ctl.nop(1);
			#1;
			b_exp = (k < 3) ? k - 1 : k - 2;
			if (b_exp == 4)
				check("float after gated burst", 16'h0003, 16'(dq_oe_n));
			else
				check("gated word", mem_exp[b_exp], dq_out);
		end
		$display("test clock gate done");
		// single-location write under the write burst bit; nops after it would land if it burst
		st = 3'($urandom);
		d = 16'($urandom);
		i_ctl.setup(12'h232, bk, row);
		i_ctl.drv(`PIN_WRITE, bk, {9'h000, st}, 2'h0, d);
		mem_exp[st] = d;
		i_ctl.nop(2);
		rd_chk(st, 4, 3, 1'b0, 2'h0);
		// a test operating mode refuses the write; normal mode reads the old word back
		i_ctl.setup(12'h0b0, bk, row);
		i_ctl.drv(`PIN_WRITE, bk, {9'h000, st}, 2'h0, ~d);
		i_ctl.setup(12'h030, bk, row);
		rd_chk(st, 1, 3, 1'b0, 2'h0);
		$display("test write mode bits done");
		print_verdict();
	end
endmodule
